// file: rtl/tss_ctrl.v
`include "tss_regs.vh"
`default_nettype none
module tss_ctrl #(
    parameter TIMEOUT_CYC = `TSS_TIMEOUT_MS * `TSS_CLK_MHZ * 1000
) (
    input  wire        clk,
    input  wire        rst,
    input  wire        sclIn,
    input  wire        sdaIn,
    output wire        sdaOut,
    output wire        sdaOe,
    input  wire [7:0]  localTemp,
    input  wire [15:0] remoteTempRaw,
    input  wire [15:0] remoteTempFilt,
    input  wire        convDone,
    output reg         convStart_ff,
    output wire        standbyReq,
    output wire [1:0]  remoteFilterSelect,
    output reg  [7:0]  alertFlags_ff,
    output wire [3:0]  conversionRateField
);
    // bus states, one-hot
    localparam [5:0] S_IDLE = 6'h01, S_ADDR = 6'h02, S_AACK = 6'h04,
                     S_RX = 6'h08, S_TX = 6'h10, S_MACK = 6'h20;

    // three-stage input sync; first stage feeds only second
    reg [2:0] sclSync_ff;
    reg [2:0] sdaSync_ff;
    reg       scl_ff;
    reg       sda_ff;
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sclSync_ff <= 3'h7;
            sdaSync_ff <= 3'h7;
            scl_ff     <= 1'b1;
            sda_ff     <= 1'b1;
        end
        else
        begin
            sclSync_ff <= {sclSync_ff[1:0], sclIn};
            sdaSync_ff <= {sdaSync_ff[1:0], sdaIn};
            // change counts once stages two and three agree
            if (sclSync_ff[1] == sclSync_ff[2])
                scl_ff <= sclSync_ff[2];
            if (sdaSync_ff[1] == sdaSync_ff[2])
                sda_ff <= sdaSync_ff[2];
        end
    end

    reg  sclPrev_ff;
    reg  sdaPrev_ff;
    wire sclRise = scl_ff & ~sclPrev_ff;
    wire sclFall = ~scl_ff & sclPrev_ff;
    wire startCond = scl_ff & sclPrev_ff & sdaPrev_ff & ~sda_ff;
    wire stopCond  = scl_ff & sclPrev_ff & ~sdaPrev_ff & sda_ff;

    // register storage
    reg [7:0] cfg_ff;      // configuration
    reg [7:0] rate_ff;     // conversion rate
    reg [7:0] lHigh_ff;
    reg [7:0] rHigh_ff;
    reg [7:0] rLow_ff;
    reg [7:0] rOfsHi_ff;
    reg [7:0] rOfsLo_ff;
    reg [7:0] enh_ff;      // enhanced config
    reg [7:0] filt_ff;     // filter and comparator mode
    reg [7:0] ptr_ff;      // register pointer

    assign remoteFilterSelect  = filt_ff[2:1];
    assign standbyReq          = cfg_ff[`TSS_B_STANDBY];
    assign conversionRateField = rate_ff[3:0];

    // fold alias offsets onto their primary address
    function [7:0] canon;
        input [7:0] a;
        begin
            case (a)
                `TSS_A_CFG_AL:   canon = `TSS_A_CFG;
                `TSS_A_RATE_AL:  canon = `TSS_A_RATE;
                `TSS_A_LHIGH_AL: canon = `TSS_A_LHIGH;
                `TSS_A_RHIGH_AL: canon = `TSS_A_RHIGH;
                `TSS_A_RLOW_AL:  canon = `TSS_A_RLOW;
                default:         canon = a;
            endcase
        end
    endfunction

    // filter on when select is standard or enhanced; reserved acts as off
    wire filterOn = (filt_ff[2:1] == `TSS_F_STD) || (filt_ff[2:1] == `TSS_F_ENH);
    // filtered value passes without added offset
    wire [15:0] remoteSel = filterOn ? remoteTempFilt : remoteTempRaw;
    wire        fineOn    = filterOn | enh_ff[`TSS_B_EXTRES];
    wire [7:0]  remoteLo  = {remoteSel[7:5], fineOn ? remoteSel[4:3] : 2'b00, 3'b000};

    // read mux
    reg [7:0] rdData;
    always @*
    begin
        case (canon(ptr_ff))
            `TSS_A_LTEMP:    rdData = localTemp;
            `TSS_A_RTEMP_HI: rdData = remoteSel[15:8];
            `TSS_A_ALERT:    rdData = alertFlags_ff;
            `TSS_A_CFG:      rdData = cfg_ff;
            `TSS_A_RATE:     rdData = rate_ff;
            `TSS_A_LHIGH:    rdData = lHigh_ff;
            `TSS_A_RHIGH:    rdData = rHigh_ff;
            `TSS_A_RLOW:     rdData = rLow_ff;
            `TSS_A_ONESHOT:  rdData = `TSS_R_ZERO;
            `TSS_A_RTEMP_LO: rdData = remoteLo;
            `TSS_A_ROFS_HI:  rdData = rOfsHi_ff;
            `TSS_A_ROFS_LO:  rdData = {rOfsLo_ff[7:5], 5'h00};
            `TSS_A_ENHCFG:   rdData = enh_ff;
            `TSS_A_FILTER:   rdData = {5'h00, filt_ff[2:0]};
            default:         rdData = `TSS_R_ZERO;
        endcase
    end

    // serial engine
    reg [5:0]  state_ff;
    reg [7:0]  shift_ff;
    reg [3:0]  bitCnt_ff;
    reg        isRead_ff;
    reg        havePtr_ff;
    reg        sdaLow_ff;   // drives data low when set
    reg [31:0] toCnt_ff;
    reg        wrStrobe;
    reg [7:0]  wrAddr;
    reg [7:0]  wrData;

    // open-drain: enable only while pulling low
    assign sdaOut = 1'b0;
    assign sdaOe  = sdaLow_ff;

    wire busTimeout = (toCnt_ff >= TIMEOUT_CYC);

    // timeout counter: runs while either line low
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            toCnt_ff <= 32'h0000_0000;
        else if (scl_ff & sda_ff)
            toCnt_ff <= 32'h0000_0000;
        else if (!busTimeout)
            toCnt_ff <= toCnt_ff + 32'h0000_0001;
    end

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_ff   <= S_IDLE;
            shift_ff   <= 8'h00;
            bitCnt_ff  <= 4'h0;
            isRead_ff  <= 1'b0;
            havePtr_ff <= 1'b0;
            sdaLow_ff  <= 1'b0;
            ptr_ff     <= 8'h00;
            sclPrev_ff <= 1'b1;
            sdaPrev_ff <= 1'b1;
            wrStrobe   <= 1'b0;
            wrAddr     <= 8'h00;
            wrData     <= 8'h00;
        end
        else
        begin
            sclPrev_ff <= scl_ff;
            sdaPrev_ff <= sda_ff;
            wrStrobe   <= 1'b0;
            if (busTimeout && sdaLow_ff)
            begin
                // held too long while we pull data low
                state_ff  <= S_IDLE;
                sdaLow_ff <= 1'b0;
            end
            else if (startCond)
            begin
                // abandon anything, wait for address
                state_ff   <= S_ADDR;
                bitCnt_ff  <= 4'h0;
                havePtr_ff <= 1'b0;
                sdaLow_ff  <= 1'b0;
            end
            else if (stopCond)
            begin
                state_ff  <= S_IDLE;
                sdaLow_ff <= 1'b0;
            end
            else
            begin
                case (state_ff)
                    S_IDLE: sdaLow_ff <= 1'b0;
                    S_ADDR, S_RX:
                    begin
                        if (sclRise)
                        begin
                            shift_ff  <= {shift_ff[6:0], sda_ff};
                            bitCnt_ff <= bitCnt_ff + 4'h1;
                        end
                        else if (sclFall && bitCnt_ff == 4'h8)
                        begin
                            bitCnt_ff <= 4'h0;
                            if (state_ff == S_ADDR)
                            begin
                                if (shift_ff[7:1] == `TSS_SLAVE_ADDR)
                                begin
                                    isRead_ff <= shift_ff[0];
                                    sdaLow_ff <= 1'b1;
                                    state_ff  <= S_AACK;
                                end
                                else
                                    state_ff <= S_IDLE;
                            end
                            else
                            begin
                                sdaLow_ff <= 1'b1;
                                state_ff  <= S_AACK;
                                if (!havePtr_ff)
                                begin
                                    ptr_ff     <= shift_ff;
                                    havePtr_ff <= 1'b1;
                                end
                                else
                                begin
                                    wrStrobe <= 1'b1;
                                    wrAddr   <= canon(ptr_ff);
                                    wrData   <= shift_ff;
                                end
                            end
                        end
                    end
                    S_AACK:
                    begin
                        // after ninth clock: release ack on a write, drive first data bit on a read
                        if (sclFall)
                        begin
                            if (isRead_ff)
                            begin
                                shift_ff  <= {rdData[6:0], 1'b0};
                                sdaLow_ff <= ~rdData[7];
                                bitCnt_ff <= 4'h1;
                                state_ff  <= S_TX;
                            end
                            else
                            begin
                                sdaLow_ff <= 1'b0;
                                state_ff  <= S_RX;
                            end
                        end
                    end
                    S_TX:
                    begin
                        if (sclFall)
                        begin
                            if (bitCnt_ff == 4'h8)
                            begin
                                sdaLow_ff <= 1'b0;
                                state_ff  <= S_MACK;
                            end
                            else
                            begin
                                sdaLow_ff <= ~shift_ff[7];
                                shift_ff  <= {shift_ff[6:0], 1'b0};
                                bitCnt_ff <= bitCnt_ff + 4'h1;
                            end
                        end
                    end
                    S_MACK:
                    begin
                        // ack repeats same byte; nack ends read
                        if (sclRise)
                            state_ff <= sda_ff ? S_IDLE : S_AACK;
                    end
                    default: state_ff <= S_IDLE;
                endcase
            end
        end
    end

    // register writes; one-shot data never stored
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cfg_ff    <= `TSS_R_CFG;
            rate_ff   <= `TSS_R_RATE;
            lHigh_ff  <= `TSS_R_LHIGH;
            rHigh_ff  <= `TSS_R_RHIGH;
            rLow_ff   <= `TSS_R_RLOW;
            rOfsHi_ff <= `TSS_R_ZERO;
            rOfsLo_ff <= `TSS_R_ZERO;
            enh_ff    <= `TSS_R_ZERO;
            filt_ff   <= `TSS_R_ZERO;
        end
        else if (wrStrobe)
        begin
            case (wrAddr)
                `TSS_A_CFG:     cfg_ff    <= wrData & 8'hE7;
                `TSS_A_RATE:    rate_ff   <= {4'h0, wrData[3:0]};
                `TSS_A_LHIGH:   lHigh_ff  <= wrData;
                `TSS_A_RHIGH:   rHigh_ff  <= wrData;
                `TSS_A_RLOW:    rLow_ff   <= wrData;
                `TSS_A_ROFS_HI: rOfsHi_ff <= wrData;
                `TSS_A_ROFS_LO: rOfsLo_ff <= {wrData[7:5], 5'h00};
                `TSS_A_ENHCFG:  enh_ff    <= wrData & 8'h7F;
                `TSS_A_FILTER:  filt_ff   <= {5'h00, wrData[2:0]};
                default:        cfg_ff    <= cfg_ff;
            endcase
        end
    end

    // one-shot and conversion busy tracking
    reg oneShotBusy_ff;
    wire oneShotHit = wrStrobe && (wrAddr == `TSS_A_ONESHOT);
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            convStart_ff   <= 1'b0;
            oneShotBusy_ff <= 1'b0;
        end
        else
        begin
            // single pulse, only while standing by
            convStart_ff <= oneShotHit && standbyReq && !oneShotBusy_ff;
            if (oneShotHit && standbyReq)
                oneShotBusy_ff <= 1'b1;
            else if (convDone)
                oneShotBusy_ff <= 1'b0;
        end
    end

    // fault queue over each finished conversion
    reg [1:0] lhCnt_ff;
    reg [1:0] rhCnt_ff;
    reg [1:0] rlCnt_ff;
    wire lhOut = $signed(localTemp) > $signed(lHigh_ff);
    wire rhOut = $signed(remoteSel[15:8]) > $signed(rHigh_ff);
    wire rlOut = $signed(remoteSel[15:8]) < $signed(rLow_ff);
    wire fq    = cfg_ff[`TSS_B_FAULTQ];

    function [1:0] qstep;
        input [1:0] c;
        input       o;
        begin
            if (!o)
                qstep = 2'd0;
            else if (c == `TSS_FAULT_COUNT)
                qstep = c;
            else
                qstep = c + 2'd1;
        end
    endfunction

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            lhCnt_ff      <= 2'd0;
            rhCnt_ff      <= 2'd0;
            rlCnt_ff      <= 2'd0;
            alertFlags_ff <= 8'h00;
        end
        else
        begin
            alertFlags_ff[`TSS_B_BUSY] <= oneShotBusy_ff;
            if (convDone)
            begin
                lhCnt_ff <= qstep(lhCnt_ff, lhOut);
                rhCnt_ff <= qstep(rhCnt_ff, rhOut);
                rlCnt_ff <= qstep(rlCnt_ff, rlOut);
                // three in a row when queue on, else one
                alertFlags_ff[`TSS_B_LHIGH] <= fq ? (qstep(lhCnt_ff, lhOut) == `TSS_FAULT_COUNT) : lhOut;
                alertFlags_ff[`TSS_B_RHIGH] <= fq ? (qstep(rhCnt_ff, rhOut) == `TSS_FAULT_COUNT) : rhOut;
                alertFlags_ff[`TSS_B_RLOW]  <= fq ? (qstep(rlCnt_ff, rlOut) == `TSS_FAULT_COUNT) : rlOut;
            end
        end
    end
endmodule
`default_nettype wire

// file: rtl/tss_regs.vh
`ifndef TSS_REGS_VH
`define TSS_REGS_VH
// register offsets
`define TSS_A_LTEMP      8'h00
`define TSS_A_RTEMP_HI   8'h01
`define TSS_A_ALERT      8'h02
`define TSS_A_CFG        8'h03
`define TSS_A_RATE       8'h04
`define TSS_A_LHIGH      8'h05
`define TSS_A_RHIGH      8'h07
`define TSS_A_RLOW       8'h08
`define TSS_A_CFG_AL     8'h09
`define TSS_A_RATE_AL    8'h0A
`define TSS_A_LHIGH_AL   8'h0B
`define TSS_A_RHIGH_AL   8'h0D
`define TSS_A_RLOW_AL    8'h0E
`define TSS_A_ONESHOT    8'h0F
`define TSS_A_RTEMP_LO   8'h10
`define TSS_A_ROFS_HI    8'h11
`define TSS_A_ROFS_LO    8'h12
`define TSS_A_ENHCFG     8'h45
`define TSS_A_FILTER     8'hBF
// reset values
`define TSS_R_CFG        8'h00
`define TSS_R_RATE       8'h08
`define TSS_R_LHIGH      8'h46
`define TSS_R_RHIGH      8'h55
`define TSS_R_RLOW       8'h00
`define TSS_R_ZERO       8'h00
// field positions
`define TSS_B_FAULTQ     0
`define TSS_B_STANDBY    6
`define TSS_B_EXTRES     6
`define TSS_B_BUSY       7
`define TSS_B_LHIGH      6
`define TSS_B_RHIGH      4
`define TSS_B_RLOW       3
// filter codes
`define TSS_F_NONE       2'b00
`define TSS_F_STD        2'b01
`define TSS_F_ENH        2'b11
// slave address and timing
`define TSS_SLAVE_ADDR   7'h4C
`define TSS_FAULT_COUNT  2'd3
`define TSS_TIMEOUT_MS   35
`define TSS_CLK_MHZ      100
`endif

// file: verif/tss_ctrl_monitor.sv
`default_nettype none
module tss_ctrl_monitor #(
    parameter int TIMEOUT_CYC = 3500000
) (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       sclIn,
    input wire logic       sdaIn,
    input wire logic       sdaOut,
    input wire logic       sdaOe,
    input wire logic       convDone,
    input wire logic       convStart_ff,
    input wire logic       standbyReq,
    input wire logic [1:0] remoteFilterSelect,
    input wire logic [7:0] alertFlags_ff,
    input wire logic [3:0] conversionRateField
);
    logic [31:0] oeCnt_ff;   // cycles we have held the data line low
    logic [4:0]  idleCnt_ff; // cycles with both lines high, saturating
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // counters for the long-window checks
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            oeCnt_ff <= 32'h0;
            idleCnt_ff <= 5'h0;
        end
        else
        begin
            oeCnt_ff <= sdaOe ? oeCnt_ff + 32'h1 : 32'h0;
            idleCnt_ff <= (sclIn && sdaIn) ? idleCnt_ff + {4'h0, idleCnt_ff != 5'h1F} : 5'h0;
        end
    end
    chk_data_open_drain: assert property (sdaOut == 1'h0)
        else $error("data pin driven high");
    chk_start_single: assert property (convStart_ff |=> !convStart_ff)
        else $error("conversion start longer than one cycle");
    chk_start_standby: assert property (convStart_ff |-> standbyReq)
        else $error("conversion start outside standby");
    chk_start_not_busy: assert property ($rose(convStart_ff) |-> !$past(alertFlags_ff[7]))
        else $error("conversion start while busy");
    // slack covers the input synchroniser; the simulated bound is short
    chk_timeout_bound: assert property (oeCnt_ff <= TIMEOUT_CYC + 20)
        else $error("data line held past bus timeout");
    chk_flags_on_conv: assert property ($changed(alertFlags_ff[6:3]) |-> $past(convDone) || $past(convDone, 2))
        else $error("limit flags moved without a conversion");
    chk_cfg_idle_stable: assert property (idleCnt_ff == 5'h1F |-> $stable(remoteFilterSelect) && $stable(standbyReq)
        && $stable(conversionRateField))
        else $error("control field changed on an idle bus");
    chk_reset_quiet: assert property ($fell(rst) |-> alertFlags_ff == 8'h00 && !standbyReq && !sdaOe)
        else $error("outputs not quiet after reset");
    cover property (convStart_ff);
    cover property (oeCnt_ff == TIMEOUT_CYC);
    cover property ($rose(alertFlags_ff[6]));
endmodule
bind tss_ctrl tss_ctrl_monitor #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_tss_ctrl_monitor (
    .clk(clk), .rst(rst), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .convDone(convDone), .convStart_ff(convStart_ff), .standbyReq(standbyReq),
    .remoteFilterSelect(remoteFilterSelect), .alertFlags_ff(alertFlags_ff),
    .conversionRateField(conversionRateField)
);
`default_nettype wire

// file: verif/tss_host_model.sv
`include "tss_regs.vh"
`default_nettype none
module tss_host_model (
    input  wire logic       clk,
    input  wire logic       sdaLine,
    output var  logic       sclDrv,
    output var  logic       sdaLow,
    output var  logic       obsValid,
    output var  logic [7:0] obsData
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF = 5; // half the clock-high phase in clocks, above the sync latency
    initial
    begin
        sclDrv = 1'h1;
        sdaLow = 1'h0;
        obsValid = 1'h0;
        obsData = 8'h00;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // data settles with the clock low, sampled mid-high
    task automatic bitOut(input logic b, output logic s);
        tick(2);
        sdaLow <= !b;
        tick(HALF);
        sclDrv <= 1'h1;
        tick(HALF);
        s = sdaLine;
        tick(HALF);
        sclDrv <= 1'h0;
    endtask
    // start is cond(0,1), stop is cond(1,0)
    task automatic cond(input logic a, input logic b);
        tick(2);
        sdaLow <= a;
        tick(HALF);
        sclDrv <= 1'h1;
        tick(HALF);
        sdaLow <= b;
        tick(HALF);
        sclDrv <= a;
    endtask
    task automatic sendByte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bitOut(d[i], s);
        bitOut(1'h1, ack);
    endtask
    task automatic recvByte(output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bitOut(1'h1, s);
            d[i] = s;
        end
        bitOut(1'h1, s); // nack closes the read
    endtask
    task automatic report(input logic [7:0] d);
        obsData <= d;
        obsValid <= 1'h1;
        @(posedge clk);
        obsValid <= 1'h0;
    endtask
    // only mapped places are ever addressed here
    task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic rdOp);
        logic k;
        logic [7:0] q;
        cond(1'h0, 1'h1);
        sendByte({`TSS_SLAVE_ADDR, 1'h0}, k);
        sendByte(a, k);
        if (rdOp)
        begin
            cond(1'h0, 1'h1);
            sendByte({`TSS_SLAVE_ADDR, 1'h1}, k);
            recvByte(q);
        end
        else
            sendByte(d, k);
        cond(1'h1, 1'h0);
        if (rdOp)
            report(q);
    endtask
    // cut a write short after nb bits, hold the clock low wt cycles
    task automatic partial(input logic [6:0] a7, input logic [7:0] p, input int nb, input int wt);
        logic s;
        logic [25:0] seq;
        seq = {a7, 1'h0, 1'h1, p, 1'h1, 8'hFF};
        cond(1'h0, 1'h1);
        for (int i = 25; i > 25 - nb; i--)
            bitOut(seq[i], s);
        tick(wt);
        report({6'h00, s, sdaLine});
    endtask
endmodule
`default_nettype wire

// file: verif/thermal_sensor_smbus_control_tb.sv
`include "tss_regs.vh"
`default_nettype none
module thermal_sensor_smbus_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TMO = 400; // short bus timeout, still above the longest low stretch of a normal transfer
    logic        clk, rst, convDone, sclLine, hostSdaLow, sdaOut, sdaOe;
    logic        convStart, standbyReq, obsValid, tbValid;
    logic [7:0]  obsData, tbData, localTemp, alertFlags, nStart;
    logic [15:0] rawT, filtT;
    logic [1:0]  filtSel;
    logic [3:0]  rateField;
    logic [7:0]  expQ[$];
    int          n_fail, samples_checked;
    wire logic   sdaLine;
    logic [7:0]  mainA[5] = '{`TSS_A_CFG, `TSS_A_RATE, `TSS_A_LHIGH, `TSS_A_RHIGH, `TSS_A_RLOW};
    logic [7:0]  aliasA[5] = '{`TSS_A_CFG_AL, `TSS_A_RATE_AL, `TSS_A_LHIGH_AL, `TSS_A_RHIGH_AL, `TSS_A_RLOW_AL};
    logic [7:0]  rstV[5] = '{8'h00, 8'h08, 8'h46, 8'h55, 8'h00};
    logic [7:0]  msk[5] = '{8'h41, 8'h0F, 8'hFF, 8'hFF, 8'hFF};
    logic [7:0]  fqT[6] = '{8'h19, 8'h50, 8'h50, 8'h19, 8'h50, 8'h50};
    // open-drain data line with its pull-up
    assign sdaLine = !(sdaOe && !sdaOut) && !hostSdaLow;
    tss_ctrl #(.TIMEOUT_CYC(TMO)) u_tss_ctrl (
        .clk(clk), .rst(rst), .sclIn(sclLine), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .localTemp(localTemp), .remoteTempRaw(rawT), .remoteTempFilt(filtT), .convDone(convDone),
        .convStart_ff(convStart), .standbyReq(standbyReq), .remoteFilterSelect(filtSel),
        .alertFlags_ff(alertFlags), .conversionRateField(rateField)
    );
    tss_host_model u_tss_host_model (
        .clk(clk), .sdaLine(sdaLine), .sclDrv(sclLine), .sdaLow(hostSdaLow),
        .obsValid(obsValid), .obsData(obsData)
    );
    initial
    begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    task automatic finish_test();
        if (n_fail == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t ns: got %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        expQ.push_back(e);
        u_tss_host_model.xfer(a, 8'h00, 1'h1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_tss_host_model.xfer(a, d, 1'h0);
    endtask
    // port sample through the same queue as bus reads
    task automatic note(input logic [7:0] v, input logic [7:0] e);
        expQ.push_back(e);
        tbData <= v;
        tbValid <= 1'h1;
        @(posedge clk);
        tbValid <= 1'h0;
        @(posedge clk);
    endtask
    task automatic conv();
        convDone <= 1'h1;
        @(posedge clk);
        convDone <= 1'h0;
        @(posedge clk);
    endtask
    // result watcher: oldest expectation against each result
    always @(posedge clk)
    begin
        if (convStart)
            nStart <= nStart + 8'h01;
        if (obsValid || tbValid)
            check(obsValid ? obsData : tbData, expQ.pop_front());
    end
    initial
    begin
        #900000;
        n_fail++;
        finish_test();
    end
    initial
    begin
        logic [7:0] v;
        logic [15:0] src;
        logic filt;
        rst = 1'h1;
        convDone = 1'h0;
        tbValid = 1'h0;
        tbData = 8'h00;
        nStart = 8'h00;
        localTemp = 8'h19;
        rawT = 16'h2000;
        filtT = 16'h2000;
        void'($urandom(61172));
        repeat (8) @(posedge clk);
        rst <= 1'h0;
        repeat (8) @(posedge clk);
        foreach (aliasA[i])
            rd(aliasA[i], rstV[i]);
        rd(`TSS_A_ROFS_HI, 8'h00);
        rd(`TSS_A_ROFS_LO, 8'h00);
        expQ.push_back(8'h03);
        u_tss_host_model.partial(`TSS_SLAVE_ADDR ^ 7'h01, 8'h00, 9, 20);
        expQ.push_back(8'h01);
        u_tss_host_model.partial(`TSS_SLAVE_ADDR, 8'h00, 9, 20);
        // both directions of each alias, defaults restored on the way
        foreach (mainA[i])
        begin
            v = 8'($urandom()) & msk[i];
            wr(aliasA[i], v);
            rd(mainA[i], v);
            wr(mainA[i], rstV[i]);
            rd(aliasA[i], rstV[i]);
        end
        note({4'h0, rateField}, 8'h08);
        repeat (3)
        begin
            v = 8'($urandom());
            localTemp <= v;
            conv();
            rd(`TSS_A_LTEMP, v);
        end
        localTemp <= 8'h19;
        // every filter code, then extended resolution with the filter off
        for (int k = 0; k < 5; k++)
        begin
            filt = k[0];
            wr(`TSS_A_FILTER, {5'h00, k[1:0], 1'h0});
            wr(`TSS_A_ENHCFG, {1'h0, k == 4, 6'h00});
            note({6'h00, filtSel}, {6'h00, k[1:0]});
            rawT <= 16'($urandom());
            filtT <= 16'($urandom());
            conv();
            src = filt ? filtT : rawT;
            rd(`TSS_A_RTEMP_HI, src[15:8]);
            rd(`TSS_A_RTEMP_LO, src[7:0] & ((filt || k == 4) ? 8'hF8 : 8'hE0));
        end
        wr(`TSS_A_ENHCFG, 8'h00);
        rawT <= 16'h2000;
        filtT <= 16'h2000;
        conv();
        wr(`TSS_A_ONESHOT, 8'hA5); // not in standby: ignored
        note(nStart, 8'h00);
        wr(`TSS_A_CFG, 8'h40);
        note({7'h00, standbyReq}, 8'h01);
        wr(`TSS_A_ONESHOT, 8'($urandom()));
        wr(`TSS_A_ONESHOT, 8'h3C); // still busy: ignored
        rd(`TSS_A_ONESHOT, 8'h00);
        rd(`TSS_A_ALERT, 8'h80);
        note(nStart, 8'h01);
        conv();
        rd(`TSS_A_ALERT, 8'h00);
        wr(`TSS_A_CFG, 8'h00);
        localTemp <= 8'h50;
        conv();
        rd(`TSS_A_ALERT, 8'h40);
        wr(`TSS_A_CFG, 8'h01);
        foreach (fqT[i])
        begin
            localTemp <= fqT[i];
            conv();
        end
        rd(`TSS_A_ALERT, 8'h00);
        conv();
        rd(`TSS_A_ALERT, 8'h40);
        expQ.push_back(8'h03);
        u_tss_host_model.partial(`TSS_SLAVE_ADDR, `TSS_A_LHIGH, 22, 20);
        rd(`TSS_A_LHIGH, `TSS_R_LHIGH);
        expQ.push_back(8'h03);
        u_tss_host_model.partial(`TSS_SLAVE_ADDR, `TSS_A_CFG, 17, TMO + 60);
        rd(`TSS_A_CFG, 8'h01);
        repeat (4) @(posedge clk);
        if (expQ.size() != 0)
            n_fail++;
        finish_test();
    end
endmodule
`default_nettype wire
